// [inc/shp_consts.svh]
// register map, field positions, reset values and timing figures
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH
`define SHP_OFF_CTRL 4'h0
`define SHP_OFF_STAT 4'h4
`define SHP_OFF_TXD 4'h8
`define SHP_OFF_RXD 4'hC
`define SHP_CTRL_BAUD 2:0
`define SHP_CTRL_PAR 4:3
`define SHP_CTRL_FLOW 6:5
`define SHP_CTRL_SER 7
`define SHP_CTRL_RST 8'h85
`define SHP_ST_TXRDY 0
`define SHP_ST_RXVLD 1
`define SHP_ST_OVR 2
`define SHP_ST_PERR 3
`define SHP_ST_FERR 4
`define SHP_ST_HHOLD 5
`define SHP_ST_OHOLD 6
`define SHP_ST_TXBSY 7
`define SHP_CLK_HZ 20000000
`define SHP_OVS 16
`define SHP_PH_MID 4'h7
`define SHP_PH_LAST 4'hF
`define SHP_BIT_LAST 4'h9
`define SHP_XON 8'h11
`define SHP_XOFF 8'h13
`define SHP_LATE_CHARS 5
`define SHP_EARLY_CHARS 15
`define SHP_BAUD_300 300
`define SHP_BAUD_600 600
`define SHP_BAUD_1200 1200
`define SHP_BAUD_2400 2400
`define SHP_BAUD_4800 4800
`define SHP_BAUD_9600 9600
`endif

// [inc/shp_pkg.sv]
// types shared by the serial host port
package shp_pkg;
	typedef enum logic [1:0] {SHP_FLOW_NONE = 2'h0, SHP_FLOW_SW = 2'h1,
		SHP_FLOW_RTS = 2'h2, SHP_FLOW_DTR = 2'h3} shp_flow_t;
	typedef enum logic [1:0] {SHP_PAR_NONE = 2'h0, SHP_PAR_ODD = 2'h1,
		SHP_PAR_EVEN = 2'h2, SHP_PAR_OFF = 2'h3} shp_par_t;
	typedef enum logic [1:0] {SHP_TX_IDLE = 2'h0,
		SHP_TX_SHIFT = 2'h1} shp_tx_t;
	typedef enum logic [1:0] {SHP_RX_IDLE = 2'h0,
		SHP_RX_FRAME = 2'h1} shp_rx_t;
endpackage : shp_pkg

// [hdl/shp_serial_port.sv]
// serial host port: avalon slave, fifos, framer, flow control
//
// Operation
// - ten-bit frame, one start, one stop
// - six baud rates, kept in non-volatile store
// - selectable parity, kept in non-volatile store
// - at most five characters after host hold-off
// - own hold-off leaves room for fifteen
// - hold-off code 19, release code 17
// - rts goes to hold-off when nearly full
// - cts hold-off stops transmission
// - dtr goes to hold-off when nearly full
// - dsr hold-off stops transmission
// - no flow mode ignores lines and codes
// - flow mode kept in non-volatile store
// - serial selected disables parallel bus port
// - port wired as terminal equipment
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`include "shp_consts.svh"

// simple ring fifo with valid/ready on both sides
module shp_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(D+1)-1:0] count
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D+1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} shp_fifo_st_t;
	shp_fifo_st_t f_reg, f_next;
	logic push, pop;

	initial
	begin
		if (D < 2 || (1 << AW) != D)
			$error("fifo depth must be a power of two");
	end

	// flags and handshakes
	assign in_ready = (f_reg.cnt != CW'(D));
	assign out_valid = (f_reg.cnt != '0);
	assign out_data = f_reg.mem[f_reg.rp];
	assign count = f_reg.cnt;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// next pointers and storage
	always_comb
	begin
		f_next = f_reg;
		if (push)
		begin
			f_next.mem[f_reg.wp] = in_data;
			f_next.wp = f_reg.wp + AW'(1);
		end
		if (pop)
			f_next.rp = f_reg.rp + AW'(1);
		if (push & ~pop)
			f_next.cnt = f_reg.cnt + CW'(1);
		else if (pop & ~push)
			f_next.cnt = f_reg.cnt - CW'(1);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			f_reg <= '0;
		else
			f_reg <= f_next;
	end
endmodule : shp_fifo

// top of the serial host port
module shp_serial_port #(
	parameter int TX_DEPTH = 4,
	parameter int RX_DEPTH = 32
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic TXD,
	input wire logic RXD,
	output logic RTS,
	input wire logic CTS,
	output logic DTR,
	input wire logic DSR,
	input wire logic [7:0] NV_CFG,
	output logic [7:0] NV_DATA,
	output logic NV_WR,
	output logic GPIB_DISABLE
);
	localparam int RCW = $clog2(RX_DEPTH+1);
	localparam logic [RCW-1:0] HOLD_AT =
		RCW'(RX_DEPTH - `SHP_EARLY_CHARS - 1);
	localparam logic [RCW-1:0] FREE_AT = RCW'(RX_DEPTH / 4);

	typedef struct packed {
		logic [7:0] ctrl;
		logic nv_loaded;
		logic nv_wr;
		logic wait_n;
		logic [31:0] rdata;
		logic [12:0] div_cnt;
		logic tick;
		shp_pkg::shp_tx_t tx_st;
		logic [9:0] tx_sh;
		logic [3:0] tx_bit;
		logic [3:0] tx_ph;
		logic txd;
		shp_pkg::shp_rx_t rx_st;
		logic [9:0] rx_sh;
		logic [3:0] rx_bit;
		logic [3:0] rx_ph;
		logic rx_prev;
		logic host_xoff;
		logic own_hold;
		logic sent_hold;
		logic rts;
		logic dtr;
		logic ovr;
		logic perr;
		logic ferr;
	} shp_st_t;
	shp_st_t s_reg, s_next;

	logic tx_in_ready, tx_out_valid, tx_out_ready, tx_in_valid;
	logic [7:0] tx_out_data;
	logic rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
	logic [7:0] rx_in_data, rx_out_data;
	logic [RCW-1:0] rx_count;
	logic req, prep, done, host_hold, sw_mode, par_on;
	logic [9:0] rx_sh_n;
	logic [7:0] rx_char;
	shp_pkg::shp_flow_t flow;
	shp_pkg::shp_par_t par;

	initial
	begin
		if (TX_DEPTH != 4 || RX_DEPTH < `SHP_EARLY_CHARS + 17)
			$error("fifo depths cannot serve the hold-off margins");
	end

	// oversample divider per baud selection, rounded down
	function automatic logic [12:0] baud_div(input logic [2:0] sel);
		int rate;
		case (sel)
			3'h0: rate = `SHP_BAUD_300;
			3'h1: rate = `SHP_BAUD_600;
			3'h2: rate = `SHP_BAUD_1200;
			3'h3: rate = `SHP_BAUD_2400;
			3'h4: rate = `SHP_BAUD_4800;
			default: rate = `SHP_BAUD_9600;
		endcase
		return 13'(`SHP_CLK_HZ / (`SHP_OVS * rate) - 1);
	endfunction : baud_div

	// parity bit over seven data bits
	function automatic logic par_bit(input logic [6:0] d,
		input shp_pkg::shp_par_t p);
		return (p == shp_pkg::SHP_PAR_ODD) ? ~^d : ^d;
	endfunction : par_bit

	// build a ten-bit frame, bit 0 goes out first
	function automatic logic [9:0] make_frame(input logic [7:0] d,
		input shp_pkg::shp_par_t p, input logic pon);
		if (pon)
			return {1'b1, par_bit(d[6:0], p), d[6:0], 1'b0};
		return {1'b1, d, 1'b0};
	endfunction : make_frame

	shp_fifo #(.W(8), .D(TX_DEPTH)) u_tx_fifo (
		.clk(CORE_CLK),
		.nrst(NRST),
		.in_valid(tx_in_valid),
		.in_ready(tx_in_ready),
		.in_data(AVS_WRITEDATA[7:0]),
		.out_valid(tx_out_valid),
		.out_ready(tx_out_ready),
		.out_data(tx_out_data),
		.count()
	);

	shp_fifo #(.W(8), .D(RX_DEPTH)) u_rx_fifo (
		.clk(CORE_CLK),
		.nrst(NRST),
		.in_valid(rx_in_valid),
		.in_ready(rx_in_ready),
		.in_data(rx_in_data),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready),
		.out_data(rx_out_data),
		.count(rx_count)
	);

	// mode decode
	assign flow = shp_pkg::shp_flow_t'(s_reg.ctrl[`SHP_CTRL_FLOW]);
	assign par = shp_pkg::shp_par_t'(s_reg.ctrl[`SHP_CTRL_PAR]);
	assign par_on = (par == shp_pkg::SHP_PAR_ODD) |
		(par == shp_pkg::SHP_PAR_EVEN);
	assign sw_mode = (flow == shp_pkg::SHP_FLOW_SW);
	assign host_hold = (sw_mode & s_reg.host_xoff)
		| ((flow == shp_pkg::SHP_FLOW_RTS) & ~CTS)
		| ((flow == shp_pkg::SHP_FLOW_DTR) & ~DSR);

	// bus handshake: one wait cycle, tx write stalls while fifo full
	assign req = AVS_READ | AVS_WRITE;
	assign prep = req & s_reg.wait_n & ~(AVS_WRITE & ~tx_in_ready &
		(AVS_ADDRESS == `SHP_OFF_TXD));
	assign done = req & ~s_reg.wait_n;
	assign tx_in_valid = done & AVS_WRITE & AVS_BYTEENABLE[0] &
		(AVS_ADDRESS == `SHP_OFF_TXD);
	assign rx_out_ready = done & AVS_READ & (AVS_ADDRESS == `SHP_OFF_RXD);

	// receive frame assembly at the stop bit sample
	assign rx_sh_n = {RXD, s_reg.rx_sh[9:1]};
	assign rx_char = par_on ? {1'b0, rx_sh_n[7:1]} : rx_sh_n[8:1];
	assign rx_in_data = rx_char;

	// tx pop and rx push strobes
	always_comb
	begin
		tx_out_ready = 1'b0;
		rx_in_valid = 1'b0;
		if (s_reg.tick && s_reg.tx_st == shp_pkg::SHP_TX_IDLE &&
			!(sw_mode && s_reg.own_hold != s_reg.sent_hold))
			tx_out_ready = ~host_hold;
		if (s_reg.tick && s_reg.rx_st == shp_pkg::SHP_RX_FRAME &&
			s_reg.rx_ph == `SHP_PH_MID && s_reg.rx_bit == `SHP_BIT_LAST)
			rx_in_valid = RXD & ~(sw_mode & ((rx_char == `SHP_XON) |
				(rx_char == `SHP_XOFF)));
	end

	// main next-state logic
	always_comb
	begin
		s_next = s_reg;
		s_next.nv_wr = 1'b0;
		// settings restored once from non-volatile store after reset
		if (!s_reg.nv_loaded)
		begin
			s_next.ctrl = NV_CFG;
			s_next.nv_loaded = 1'b1;
		end
		// bus slave
		if (prep)
		begin
			s_next.wait_n = 1'b0;
			s_next.rdata = '0;
			if (AVS_ADDRESS == `SHP_OFF_CTRL)
				s_next.rdata[7:0] = s_reg.ctrl;
			else if (AVS_ADDRESS == `SHP_OFF_STAT)
			begin
				s_next.rdata[`SHP_ST_TXRDY] = tx_in_ready;
				s_next.rdata[`SHP_ST_RXVLD] = rx_out_valid;
				s_next.rdata[`SHP_ST_OVR] = s_reg.ovr;
				s_next.rdata[`SHP_ST_PERR] = s_reg.perr;
				s_next.rdata[`SHP_ST_FERR] = s_reg.ferr;
				s_next.rdata[`SHP_ST_HHOLD] = host_hold;
				s_next.rdata[`SHP_ST_OHOLD] = s_reg.own_hold;
				s_next.rdata[`SHP_ST_TXBSY] =
					(s_reg.tx_st != shp_pkg::SHP_TX_IDLE);
			end
			else if (AVS_ADDRESS == `SHP_OFF_RXD)
				s_next.rdata[7:0] = rx_out_valid ? rx_out_data : 8'h00;
		end
		else if (done)
			s_next.wait_n = 1'b1;
		if (done && AVS_WRITE && AVS_BYTEENABLE[0])
		begin
			if (AVS_ADDRESS == `SHP_OFF_CTRL)
			begin
				s_next.ctrl = AVS_WRITEDATA[7:0];
				s_next.nv_wr = 1'b1;
			end
			else if (AVS_ADDRESS == `SHP_OFF_STAT)
			begin
				if (AVS_WRITEDATA[`SHP_ST_OVR])
					s_next.ovr = 1'b0;
				if (AVS_WRITEDATA[`SHP_ST_PERR])
					s_next.perr = 1'b0;
				if (AVS_WRITEDATA[`SHP_ST_FERR])
					s_next.ferr = 1'b0;
			end
		end
		// oversample tick generator
		s_next.tick = 1'b0;
		if (s_reg.div_cnt == 13'h0000)
		begin
			s_next.div_cnt = baud_div(s_reg.ctrl[`SHP_CTRL_BAUD]);
			s_next.tick = 1'b1;
		end
		else
			s_next.div_cnt = s_reg.div_cnt - 13'h0001;
		// own hold-off with hysteresis
		if (rx_count >= HOLD_AT)
			s_next.own_hold = 1'b1;
		else if (rx_count <= FREE_AT)
			s_next.own_hold = 1'b0;
		// pin levels follow the mode that takes effect at this edge
		s_next.rts = (s_next.ctrl[`SHP_CTRL_FLOW] ==
			shp_pkg::SHP_FLOW_RTS) ? ~s_next.own_hold : 1'b1;
		s_next.dtr = (s_next.ctrl[`SHP_CTRL_FLOW] ==
			shp_pkg::SHP_FLOW_DTR) ? ~s_next.own_hold : 1'b1;
		if (!sw_mode)
		begin
			s_next.host_xoff = 1'b0;
			s_next.sent_hold = 1'b0;
		end
		// transmitter
		case (s_reg.tx_st)
			shp_pkg::SHP_TX_IDLE:
			begin
				s_next.txd = 1'b1;
				if (s_reg.tick)
				begin
					if (sw_mode && s_reg.own_hold != s_reg.sent_hold)
					begin
						s_next.tx_sh = make_frame(s_reg.own_hold ?
							`SHP_XOFF : `SHP_XON, par, par_on);
						s_next.sent_hold = s_reg.own_hold;
						s_next.tx_st = shp_pkg::SHP_TX_SHIFT;
					end
					else if (tx_out_ready && tx_out_valid)
					begin
						s_next.tx_sh = make_frame(tx_out_data, par, par_on);
						s_next.tx_st = shp_pkg::SHP_TX_SHIFT;
					end
					s_next.tx_bit = 4'h0;
					s_next.tx_ph = 4'h0;
					// start bit only when a frame was loaded; idle stays high
					if (s_next.tx_st == shp_pkg::SHP_TX_SHIFT)
						s_next.txd = s_next.tx_sh[0];
				end
			end
			shp_pkg::SHP_TX_SHIFT:
			begin
				if (s_reg.tick)
				begin
					s_next.tx_ph = s_reg.tx_ph + 4'h1;
					if (s_reg.tx_ph == `SHP_PH_LAST)
					begin
						s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
						s_next.txd = s_next.tx_sh[0];
						s_next.tx_bit = s_reg.tx_bit + 4'h1;
						if (s_reg.tx_bit == `SHP_BIT_LAST)
						begin
							s_next.txd = 1'b1;
							s_next.tx_st = shp_pkg::SHP_TX_IDLE;
						end
					end
				end
			end
			default:
				s_next.tx_st = shp_pkg::SHP_TX_IDLE;
		endcase
		// receiver
		case (s_reg.rx_st)
			shp_pkg::SHP_RX_IDLE:
			begin
				if (s_reg.tick)
				begin
					s_next.rx_prev = RXD;
					if (s_reg.rx_prev && !RXD)
					begin
						s_next.rx_st = shp_pkg::SHP_RX_FRAME;
						s_next.rx_ph = 4'h1;
						s_next.rx_bit = 4'h0;
					end
				end
			end
			shp_pkg::SHP_RX_FRAME:
			begin
				if (s_reg.tick)
				begin
					s_next.rx_ph = s_reg.rx_ph + 4'h1;
					if (s_reg.rx_ph == `SHP_PH_MID)
					begin
						s_next.rx_sh = rx_sh_n;
						s_next.rx_bit = s_reg.rx_bit + 4'h1;
						if (s_reg.rx_bit == 4'h0 && RXD)
							s_next.rx_st = shp_pkg::SHP_RX_IDLE;
						if (s_reg.rx_bit == `SHP_BIT_LAST)
						begin
							s_next.rx_st = shp_pkg::SHP_RX_IDLE;
							s_next.rx_prev = RXD;
							if (!RXD)
								s_next.ferr = 1'b1;
							else
							begin
								if (par_on && rx_sh_n[8] !=
									par_bit(rx_sh_n[7:1], par))
									s_next.perr = 1'b1;
								if (sw_mode && rx_char == `SHP_XOFF)
									s_next.host_xoff = 1'b1;
								else if (sw_mode && rx_char == `SHP_XON)
									s_next.host_xoff = 1'b0;
								else if (!rx_in_ready)
									s_next.ovr = 1'b1;
							end
						end
					end
				end
			end
			default:
				s_next.rx_st = shp_pkg::SHP_RX_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			s_reg <= '0;
			s_reg.ctrl <= `SHP_CTRL_RST;
			s_reg.wait_n <= 1'b1;
			s_reg.txd <= 1'b1;
			s_reg.rx_prev <= 1'b1;
			s_reg.rts <= 1'b1;
			s_reg.dtr <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// outputs straight from flops; terminal-side pin roles
	assign AVS_READDATA = s_reg.rdata;
	assign AVS_WAITREQUEST = s_reg.wait_n;
	assign TXD = s_reg.txd;
	assign RTS = s_reg.rts;
	assign DTR = s_reg.dtr;
	assign NV_DATA = s_reg.ctrl;
	assign NV_WR = s_reg.nv_wr;
	assign GPIB_DISABLE = s_reg.ctrl[`SHP_CTRL_SER];
endmodule : shp_serial_port

// [bench/shp_host_model.sv]
// host serial port model facing the device pins
`timescale 1ns/10ps
module shp_host_model #(
	parameter int BIT_CLKS = 2080
) (
	input wire logic clk,
	input wire logic txd,
	input wire logic hold,
	input wire logic send,
	input wire logic [7:0] send_byte,
	output logic rxd,
	output logic cts,
	output logic dsr,
	output logic [7:0] got_byte,
	output logic got_ok
);
	logic [9:0] frm_tx;
	logic [9:0] frm_rx;
	// host hold-off lines, low asks the device to pause
	assign cts = ~hold;
	assign dsr = ~hold;
	// frame sender: start low, lsb first, stop high, idle high
	initial
	begin
		rxd = 1'b1;
		forever
		begin
			@(posedge clk);
			if (send)
			begin
				frm_tx = {1'b1, send_byte, 1'b0};
				for (int i = 0; i < 10; i++)
				begin
					rxd <= frm_tx[i];
					repeat (BIT_CLKS) @(posedge clk);
				end
			end
		end
	end
	// frame receiver sampling each bit near its centre
	initial
	begin
		got_ok = 1'b0;
		got_byte = 8'h00;
		forever
		begin
			@(negedge txd);
			repeat (BIT_CLKS / 2) @(posedge clk);
			for (int i = 0; i < 10; i++)
			begin
				frm_rx[i] = txd;
				repeat (BIT_CLKS) @(posedge clk);
			end
			got_byte = frm_rx[8:1];
			got_ok = !frm_rx[0] && frm_rx[9];
		end
	end
endmodule : shp_host_model

// [bench/shp_serial_port_assertions.sv]
// bound checker for the serial host port top
`timescale 1ns/10ps
module shp_serial_port_checker #(
	parameter int IDLE_MIN = 20800
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic TXD,
	input wire logic RTS,
	input wire logic CTS,
	input wire logic DTR,
	input wire logic [7:0] NV_DATA,
	input wire logic NV_WR,
	input wire logic GPIB_DISABLE
);
	logic ctrl_wr;
	logic held;
	int idle_cnt;
	int held_cnt;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);
	// control write and host hold-off decode
	assign ctrl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 &&
		AVS_BYTEENABLE[0];
	assign held = NV_DATA[6:5] == 2'h2 && !CTS;
	// run lengths of idle line and of hold-off
	always_ff @(posedge CORE_CLK or negedge NRST)
		if (!NRST)
		begin
			idle_cnt <= 0;
			held_cnt <= 0;
		end
		else
		begin
			idle_cnt <= TXD ? idle_cnt + 1 : 0;
			held_cnt <= held ? held_cnt + 1 : 0;
		end
	sequence s_rd_ctrl;
		AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 ##1 !AVS_WAITREQUEST;
	endsequence
	sequence s_rd_hole;
		AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0
			##1 !AVS_WAITREQUEST;
	endsequence
	property p_read_ans;
		AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
	endproperty
	property p_wait_one;
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST;
	endproperty
	property p_ctrl_read;
		s_rd_ctrl |-> AVS_READDATA[7:0] == NV_DATA;
	endproperty
	property p_hole;
		s_rd_hole |-> AVS_READDATA == 32'h0;
	endproperty
	property p_gpib;
		ctrl_wr |=> GPIB_DISABLE == $past(AVS_WRITEDATA[7]);
	endproperty
	property p_nv_wr;
		NV_WR |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
	endproperty
	property p_rts;
		!RTS |-> NV_DATA[6:5] == 2'h2;
	endproperty
	property p_dtr;
		!DTR |-> NV_DATA[6:5] == 2'h3;
	endproperty
	property p_quiet;
		held_cnt >= 4 && idle_cnt >= IDLE_MIN |=> TXD;
	endproperty
	property p_start;
		$fell(TXD) |=> !TXD [*8];
	endproperty
	a_read_ans: assert property (p_read_ans) else $error("read unanswered");
	a_wait_one: assert property (p_wait_one) else $error("answer too long");
	a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
	a_hole: assert property (p_hole) else $error("unmapped read");
	a_gpib: assert property (p_gpib) else $error("bus disable");
	a_nv_wr: assert property (p_nv_wr) else $error("store pulse");
	a_rts: assert property (p_rts) else $error("rts hold");
	a_dtr: assert property (p_dtr) else $error("dtr hold");
	a_quiet: assert property (p_quiet) else $error("sent in hold");
	a_start: assert property (p_start) else $error("short start");
endmodule : shp_serial_port_checker

bind shp_serial_port shp_serial_port_checker shp_serial_port_checker_i (
	.CORE_CLK(CORE_CLK),
	.NRST(NRST),
	.AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.TXD(TXD),
	.RTS(RTS),
	.CTS(CTS),
	.DTR(DTR),
	.NV_DATA(NV_DATA),
	.NV_WR(NV_WR),
	.GPIB_DISABLE(GPIB_DISABLE)
);

// [bench/tb.sv]
// self-checking bench for the serial host port
`timescale 1ns/10ps
module tb;
	typedef struct {
		logic wr;
		logic [3:0] a;
		logic [31:0] d;
		logic [3:0] be;
		logic [31:0] exp;
	} shp_row_t;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'h0;
	logic [31:0] rdata;
	logic wreq, txd, rxd, rts, cts, dtr, dsr, nv_wr, gpib_dis, got_ok;
	logic [7:0] nv_data;
	logic [7:0] got_byte;
	logic hold = 1'b0;
	logic send = 1'b0;
	logic [7:0] send_byte = 8'h00;
	logic [7:0] nv_cfg = 8'h85;
	logic [31:0] q;
	int n;
	int n_errors = 0;
	int cmp_count = 0;
	// register rows: direction, address, data, lanes, expected read
	shp_row_t rows [12] = '{
		'{0, 4'h0, 32'h0, 4'hF, 32'h85}, '{0, 4'h4, 32'h0, 4'hF, 32'h01},
		'{0, 4'hC, 32'h0, 4'hF, 32'h00}, '{0, 4'h6, 32'h0, 4'hF, 32'h00},
		'{1, 4'h0, 32'hC5, 4'h0, 32'h0}, '{0, 4'h0, 32'h0, 4'hF, 32'h85},
		'{1, 4'h6, 32'hFF, 4'hF, 32'h0}, '{0, 4'h0, 32'h0, 4'hF, 32'h85},
		'{1, 4'h0, 32'hC5, 4'h1, 32'h0}, '{0, 4'h0, 32'h0, 4'hF, 32'hC5},
		'{1, 4'h0, 32'h85, 4'h1, 32'h0}, '{0, 4'h0, 32'h0, 4'hF, 32'h85}};
	always #25 clk = ~clk;
	shp_serial_port shp_serial_port_i (.CORE_CLK(clk), .NRST(nrst),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .TXD(txd), .RXD(rxd), .RTS(rts), .CTS(cts),
		.DTR(dtr), .DSR(dsr), .NV_CFG(nv_cfg), .NV_DATA(nv_data),
		.NV_WR(nv_wr), .GPIB_DISABLE(gpib_dis));
	shp_host_model #(.BIT_CLKS(2080)) shp_host_model_i (.clk(clk),
		.txd(txd), .hold(hold), .send(send), .send_byte(send_byte),
		.rxd(rxd), .cts(cts), .dsr(dsr), .got_byte(got_byte),
		.got_ok(got_ok));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] b, output logic [31:0] r);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		be <= b;
		rd <= !w;
		wr <= w;
		while (wreq !== 1'b0)
			@(posedge clk);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(wreq, 1'b0);
	endtask : bus
	task automatic finish_test();
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// watchdog
	initial
	begin
		#4000000;
		n_errors++;
		finish_test();
	end
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		chk({wreq, txd, rts, dtr, gpib_dis, nv_wr}, 6'b111110);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		foreach (rows[i])
		begin
			bus(rows[i].wr, rows[i].a, rows[i].d, rows[i].be, q);
			if (!rows[i].wr)
				chk(q, rows[i].exp);
		end
		// both directions at once in the no-flow mode
		bus(1'b1, 4'h8, 32'h5A, 4'hF, q);
		send_byte <= 8'hC3;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		n = 0;
		while (got_ok !== 1'b1 && n < 30000)
		begin
			@(posedge clk);
			n++;
		end
		chk({got_ok, got_byte}, 9'h15A);
		repeat (2080) @(posedge clk);
		bus(1'b0, 4'hC, 32'h0, 4'hF, q);
		chk(q, 32'hC3);
		// rts/cts mode with host hold-off, fill the tx fifo
		hold <= 1'b1;
		bus(1'b1, 4'h0, 32'hC5, 4'hF, q);
		for (int i = 1; i < 5; i++)
			bus(1'b1, 4'h8, 32'h11 * i, 4'hF, q);
		bus(1'b0, 4'h4, 32'h0, 4'hF, q);
		chk(q, 32'h20);
		n = 0;
		repeat (21000)
		begin
			@(posedge clk);
			n += (txd !== 1'b1);
		end
		chk(n, 0);
		chk(rts, 1'b1);
		bus(1'b1, 4'h0, 32'hE5, 4'hF, q);
		bus(1'b0, 4'h4, 32'h0, 4'hF, q);
		chk(q[5], 1'b1);
		// no flow control: lines ignored, sending resumes
		bus(1'b1, 4'h0, 32'h85, 4'hF, q);
		n = 0;
		while (txd === 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		chk(txd, 1'b0);
		// mid-run reset, settings come back from the store
		nrst <= 1'b0;
		nv_cfg <= 8'hB5;
		repeat (2) @(posedge clk);
		chk({wreq, txd, rts, dtr, gpib_dis, nv_wr}, 6'h3E);
		chk(nv_data, 8'h85);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		chk({gpib_dis, nv_data}, 9'h1B5);
		bus(1'b0, 4'h0, 32'h0, 4'hF, q);
		chk(q, 32'hB5);
		// host hold-off code with even parity in software mode
		send_byte <= 8'h93;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		repeat (21000) @(posedge clk);
		bus(1'b0, 4'h4, 32'h0, 4'hF, q);
		chk(q, 32'h21);
		bus(1'b0, 4'hC, 32'h0, 4'hF, q);
		chk(q, 32'h0);
		finish_test();
	end
endmodule : tb
